// *** pph_map.svh ***
`ifndef PPH_MAP_SVH
`define PPH_MAP_SVH
`define PPH_A_P0_DATA 8'h00
`define PPH_A_P1_DATA 8'h04
`define PPH_A_P4_DATA 8'h08
`define PPH_A_P0_DIR 8'h0C
`define PPH_A_P1_DIR 8'h10
`define PPH_A_HS_CTRL 8'h14
`define PPH_A_P1_ALT 8'h18
`define PPH_A_EDGE 8'h1C
`define PPH_A_PEND 8'h20
`define PPH_A_STAT 8'h24
`define PPH_F_LO_MODE 1:0
`define PPH_F_HI_MODE 3:2
`define PPH_F_JOINT 4
`define PPH_F_EXPAND 5
`define PPH_F_GPBUS 6
`define PPH_F_XI2_RISE 0
`define PPH_F_P12_FALL 1
`define PPH_F_P13_MODE 3:2
`define PPH_P4_STROBE_LOW_LANE 0
`define PPH_P4_STROBE_HIGH_LANE 1
`define PPH_P4_B12 2
`define PPH_P4_B13 3
`define PPH_P1_XI0 4
`define PPH_P1_XI1 5
`define PPH_P1_XI2 6
`define PPH_RST_DIR 16'h0000
`define PPH_RST_OUT 16'h0000
`define PPH_RST_ALT 7'h00
`define PPH_RST_P4 4'h0
`endif

// *** pph_pkg.sv ***
package pph_pkg;
  typedef enum logic [1:0] {
    PPH_GP = 2'b00,
    PPH_IN = 2'b01,
    PPH_OUT = 2'b10,
    PPH_BIDIR = 2'b11
  } pph_mode_e;
  typedef enum logic [1:0] {
    PPH_E_RISE = 2'b00,
    PPH_E_FALL = 2'b01,
    PPH_E_BOTH = 2'b10
  } pph_edge_e;
  typedef struct packed {
    logic out_full;
    logic in_full;
    logic [7:0] in_data;
  } pph_lane_s;
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
  } pph_pins_s;
  typedef struct packed {
    logic [15:0] p0_out;
    logic [15:0] p0_dir;
    logic [15:0] p1_out;
    logic [15:0] p1_dir;
    logic [6:0] p1_alt;
    logic [3:0] p4_out;
    pph_mode_e hs_lo;
    pph_mode_e hs_hi;
    logic joint;
    logic expand;
    logic gpbus;
    logic xi2_rise;
    logic p12_fall;
    pph_edge_e p13_mode;
    pph_lane_s [1:0] lane;
    logic [15:0] p0_s1;
    logic [15:0] p0_s2;
    logic [15:0] p1_s1;
    logic [15:0] p1_s2;
    logic [3:0] p4_s1;
    logic [3:0] p4_s2;
    logic [3:0] p4_d;
    logic [2:0] p1_d;
    logic [6:0] pend;
    logic xi0_ext;
    logic ack;
    logic [31:0] dat;
    pph_pins_s pins0;
    pph_pins_s pins1;
    logic [1:0] rdy;
  } pph_state_s;
endpackage : pph_pkg

// *** pph_io.sv ***
// Functional notes
// - every port 0 bit is individually software programmable as input or output.
// - port 0 bytes set separately or jointly as input, output or bidirectional lanes; bidirectional on either byte makes both bytes bidirectional.
// - every port 1 bit has its own direction bit.
// - port 1 bits 0 to 6 may be handed to alternate functions.
// - selectable-edge interrupt fires on rising or falling edge, per software.
// - fixed-edge interrupt fires only on a falling pin edge.
// - low-level interrupt requests service while its pin stays low.
// - level interrupt is internally vectored, or fetched externally on expanded bus.
// - port 4 bits 8,9,14,15 are outputs only; bits 10 to 13 inputs only.
// - port 4 bits 10 and 11 interrupt on rising edges.
// - bit 12 interrupts rising or falling; bit 13 rising, falling or both.
// - in input mode pins are captured on the strobe's falling edge.
// - in bidirectional mode port 0 is driven only while high strobe is high.
// - in bidirectional mode high strobe falling edge acknowledges the output data.
// - in bidirectional mode low strobe falling edge latches input data.
// - output mode ready rises once software loaded the output register.
// - input mode ready is high while the input register is empty.
// - bidirectional high ready is high while output data awaits transfer.
// - bidirectional low ready is high while the input register is empty.
// - in expanded bus mode port 0 stops serving as handshake i/o.
//
// The placing of the registers and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`include "pph_map.svh"
module pph_io (
  input wire logic clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] p0_in,
  output pph_pkg::pph_pins_s p0_pins,
  input wire logic [15:0] p1_in,
  output pph_pkg::pph_pins_s p1_pins,
  input wire logic strobe_low_lane,
  input wire logic strobe_high_lane,
  input wire logic port4_input_bit12,
  input wire logic port4_input_bit13,
  output logic ready_low_lane,
  output logic ready_high_lane,
  output logic [1:0] p4_gp_out,
  output logic [6:0] irq_pending,
  output logic xi0_vector_external
);
  import pph_pkg::*;

  pph_state_s s;
  pph_state_s n;

  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [15:0] nw,
    input logic [1:0] sel
  );
    merge16 = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  endfunction : merge16

  function automatic logic lane_rdy(input pph_mode_e m, input pph_lane_s l);
    lane_rdy = (m == PPH_OUT) ? l.out_full : ~l.in_full;
  endfunction : lane_rdy

  always_comb begin
    logic req;
    logic wr;
    logic rd;
    logic [3:0] r4;
    logic [3:0] f4;
    logic r6;
    logic f6;
    logic f5;
    logic bidir;
    pph_mode_e [1:0] m;
    logic [15:0] p0_rd;
    logic [6:0] ev;
    logic [6:0] w1c;
    logic [31:0] rdat;
    int unsigned st;
    n = s;
    st = 0;
    p0_rd = 16'h0000;
    rdat = 32'h00000000;
    req = wb_cyc_i & wb_stb_i;
    // the access acts at the edge where the master sees ack
    wr = req & s.ack & wb_we_i;
    rd = req & s.ack & ~wb_we_i;
    // only the second stage feeds logic; the first may be metastable
    n.p0_s1 = p0_in;
    n.p0_s2 = s.p0_s1;
    n.p1_s1 = p1_in;
    n.p1_s2 = s.p1_s1;
    n.p4_s1 = {port4_input_bit13, port4_input_bit12, strobe_high_lane, strobe_low_lane};
    n.p4_s2 = s.p4_s1;
    n.p4_d = s.p4_s2;
    n.p1_d = s.p1_s2[6:4];
    r4 = s.p4_s2 & ~s.p4_d;
    f4 = ~s.p4_s2 & s.p4_d;
    r6 = s.p1_s2[`PPH_P1_XI2] & ~s.p1_d[2];
    f6 = ~s.p1_s2[`PPH_P1_XI2] & s.p1_d[2];
    f5 = ~s.p1_s2[`PPH_P1_XI1] & s.p1_d[1];
    m[0] = s.hs_lo;
    m[1] = s.joint ? s.hs_lo : s.hs_hi;
    bidir = (m[0] == PPH_BIDIR) || (m[1] == PPH_BIDIR);
    if (bidir) begin
      m[0] = PPH_BIDIR;
      m[1] = PPH_BIDIR;
    end
    n.pins0.out = s.p0_out;
    for (int i = 0; i < 2; i++) begin
      st = s.joint ? `PPH_P4_STROBE_LOW_LANE : (`PPH_P4_STROBE_LOW_LANE + i);
      if (rd && wb_adr_i == `PPH_A_P0_DATA && wb_sel_i[i]) begin
        n.lane[i].in_full = 1'b0;
      end
      unique case (m[i])
        PPH_GP: begin
          n.pins0.oe[8*i +: 8] = s.p0_dir[8*i +: 8];
          n.lane[i].out_full = 1'b0;
          n.lane[i].in_full = 1'b0;
        end
        PPH_IN: begin
          n.pins0.oe[8*i +: 8] = 8'h00;
          if (f4[st]) begin
            n.lane[i].in_full = 1'b1;
            n.lane[i].in_data = s.p0_s2[8*i +: 8];
          end
        end
        PPH_OUT: begin
          n.pins0.oe[8*i +: 8] = 8'hFF;
          if (r4[st]) begin
            n.lane[i].out_full = 1'b0;
          end
        end
        PPH_BIDIR: begin
          n.pins0.oe[8*i +: 8] = {8{s.p4_s2[`PPH_P4_STROBE_HIGH_LANE]}};
          if (f4[`PPH_P4_STROBE_HIGH_LANE]) begin
            n.lane[i].out_full = 1'b0;
          end
          if (f4[`PPH_P4_STROBE_LOW_LANE]) begin
            n.lane[i].in_full = 1'b1;
            n.lane[i].in_data = s.p0_s2[8*i +: 8];
          end
        end
      endcase
      // a load in the same cycle as an acknowledge leaves the lane full
      if (wr && wb_adr_i == `PPH_A_P0_DATA && wb_sel_i[i] &&
          (m[i] == PPH_OUT || m[i] == PPH_BIDIR)) begin
        n.lane[i].out_full = 1'b1;
      end
      if (s.expand) begin
        n.pins0.oe[8*i +: 8] = 8'h00;
      end
    end
    if (s.expand) begin
      n.rdy = s.p4_out[1:0];
    end else if (bidir) begin
      n.rdy[1] = s.lane[0].out_full | s.lane[1].out_full;
      n.rdy[0] = ~(s.lane[0].in_full | s.lane[1].in_full);
    end else begin
      n.rdy[0] = (m[0] == PPH_GP) ? s.p4_out[0] : lane_rdy(m[0], s.lane[0]);
      n.rdy[1] = (m[1] == PPH_GP || s.joint) ? s.p4_out[1] : lane_rdy(m[1], s.lane[1]);
    end
    n.pins1.out = s.p1_out;
    // alternate pins are released to their own function
    n.pins1.oe = s.p1_dir & ~{9'h000, s.p1_alt};
    ev = 7'h00;
    ev[0] = s.p1_alt[`PPH_P1_XI2] & (s.xi2_rise ? r6 : f6);
    ev[1] = s.p1_alt[`PPH_P1_XI1] & f5;
    ev[3] = r4[`PPH_P4_STROBE_LOW_LANE];
    ev[4] = r4[`PPH_P4_STROBE_HIGH_LANE];
    ev[5] = s.p12_fall ? f4[`PPH_P4_B12] : r4[`PPH_P4_B12];
    unique case (s.p13_mode)
      PPH_E_RISE: ev[6] = r4[`PPH_P4_B13];
      PPH_E_FALL: ev[6] = f4[`PPH_P4_B13];
      PPH_E_BOTH: ev[6] = r4[`PPH_P4_B13] | f4[`PPH_P4_B13];
      default: ev[6] = 1'b0;
    endcase
    w1c = (wr && wb_adr_i == `PPH_A_PEND && wb_sel_i[0]) ? wb_dat_i[6:0] : 7'h00;
    n.pend = (s.pend & ~w1c) | ev;
    // the level source follows the pin and cannot be cleared by software
    n.pend[2] = s.p1_alt[`PPH_P1_XI0] & ~s.p1_s2[`PPH_P1_XI0];
    n.xi0_ext = s.gpbus & s.expand & s.pend[2];
    if (wr) begin
      unique case (wb_adr_i)
        `PPH_A_P0_DATA: n.p0_out = merge16(s.p0_out, wb_dat_i[15:0], wb_sel_i[1:0]);
        `PPH_A_P1_DATA: n.p1_out = merge16(s.p1_out, wb_dat_i[15:0], wb_sel_i[1:0]);
        `PPH_A_P4_DATA: begin
          if (wb_sel_i[0]) begin
            n.p4_out = {wb_dat_i[7:6], wb_dat_i[1:0]};
          end
        end
        `PPH_A_P0_DIR: n.p0_dir = merge16(s.p0_dir, wb_dat_i[15:0], wb_sel_i[1:0]);
        `PPH_A_P1_DIR: n.p1_dir = merge16(s.p1_dir, wb_dat_i[15:0], wb_sel_i[1:0]);
        `PPH_A_HS_CTRL: begin
          if (wb_sel_i[0]) begin
            n.hs_lo = pph_mode_e'(wb_dat_i[`PPH_F_LO_MODE]);
            n.hs_hi = pph_mode_e'(wb_dat_i[`PPH_F_HI_MODE]);
            n.joint = wb_dat_i[`PPH_F_JOINT];
            n.expand = wb_dat_i[`PPH_F_EXPAND];
            n.gpbus = wb_dat_i[`PPH_F_GPBUS];
          end
        end
        `PPH_A_P1_ALT: begin
          if (wb_sel_i[0]) begin
            n.p1_alt = wb_dat_i[6:0];
          end
        end
        `PPH_A_EDGE: begin
          if (wb_sel_i[0]) begin
            n.xi2_rise = wb_dat_i[`PPH_F_XI2_RISE];
            n.p12_fall = wb_dat_i[`PPH_F_P12_FALL];
            n.p13_mode = pph_edge_e'(wb_dat_i[`PPH_F_P13_MODE]);
          end
        end
        default: begin
        end
      endcase
    end
    for (int i = 0; i < 2; i++) begin
      p0_rd[8*i +: 8] = (m[i] == PPH_IN || m[i] == PPH_BIDIR) ?
                        s.lane[i].in_data : s.p0_s2[8*i +: 8];
    end
    unique case (wb_adr_i)
      `PPH_A_P0_DATA: rdat = {16'h0000, p0_rd};
      `PPH_A_P1_DATA: rdat = {16'h0000, (s.p1_out & s.p1_dir) | (s.p1_s2 & ~s.p1_dir)};
      `PPH_A_P4_DATA: rdat = {24'h000000, s.p4_out[3:2], s.p4_s2, s.p4_out[1:0]};
      `PPH_A_P0_DIR: rdat = {16'h0000, s.p0_dir};
      `PPH_A_P1_DIR: rdat = {16'h0000, s.p1_dir};
      `PPH_A_HS_CTRL: rdat = {25'h0000000, s.gpbus, s.expand, s.joint, s.hs_hi, s.hs_lo};
      `PPH_A_P1_ALT: rdat = {25'h0000000, s.p1_alt};
      `PPH_A_EDGE: rdat = {28'h0000000, s.p13_mode, s.p12_fall, s.xi2_rise};
      `PPH_A_PEND: rdat = {25'h0000000, s.pend};
      `PPH_A_STAT: rdat = {26'h0000000, s.rdy, s.lane[1].in_full, s.lane[0].in_full,
                           s.lane[1].out_full, s.lane[0].out_full};
      default: rdat = 32'h00000000;
    endcase
    n.ack = req & ~s.ack;
    n.dat = (req & ~s.ack) ? rdat : 32'h00000000;
    if (srst) begin
      n = '0;
      n.p0_out = `PPH_RST_OUT;
      n.p1_out = `PPH_RST_OUT;
      n.p0_dir = `PPH_RST_DIR;
      n.p1_dir = `PPH_RST_DIR;
      n.p1_alt = `PPH_RST_ALT;
      n.p4_out = `PPH_RST_P4;
    end
  end

  always_ff @(posedge clk) begin
    s <= n;
  end

  assign wb_dat_o = s.dat;
  assign wb_ack_o = s.ack;
  assign p0_pins = s.pins0;
  assign p1_pins = s.pins1;
  assign ready_low_lane = s.rdy[0];
  assign ready_high_lane = s.rdy[1];
  assign p4_gp_out = s.p4_out[3:2];
  assign irq_pending = s.pend;
  assign xi0_vector_external = s.xi0_ext;
endmodule : pph_io

// *** pph_io_monitor.sv ***
`timescale 1ns/1ps
module pph_monitor (
  input wire logic clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [15:0] p1_in,
  input wire logic strobe_low_lane,
  input wire logic strobe_high_lane,
  input wire logic [6:0] irq_pending
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // three steady samples; the synchroniser counts an edge after a single sample
  sequence s_lo_rise;
    $rose(strobe_low_lane) ##1 strobe_low_lane [*3];
  endsequence
  sequence s_hi_rise;
    $rose(strobe_high_lane) ##1 strobe_high_lane [*3];
  endsequence
  sequence s_fix_fall;
    $fell(p1_in[5]) ##1 !p1_in[5] [*3];
  endsequence
  property p_ack_resp;
    s_req |=> wb_ack_o;
  endproperty
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  property p_lo_irq;
    s_lo_rise |-> ##[0:3] irq_pending[3];
  endproperty
  property p_hi_irq;
    s_hi_rise |-> ##[0:3] irq_pending[4];
  endproperty
  property p_fix_irq;
    s_fix_fall |-> ##[0:3] irq_pending[1];
  endproperty
  property p_level_irq;
    !p1_in[4] [*5] |-> irq_pending[2];
  endproperty
  property p_lo_cause;
    $rose(irq_pending[3]) |-> $past(strobe_low_lane, 2);
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  a_lo_irq: assert property (p_lo_irq) else $error("low strobe rise lost");
  a_hi_irq: assert property (p_hi_irq) else $error("high strobe rise lost");
  a_fix_irq: assert property (p_fix_irq) else $error("falling edge lost");
  a_level_irq: assert property (p_level_irq) else $error("low level lost");
  a_lo_cause: assert property (p_lo_cause) else $error("pending without edge");
endmodule : pph_monitor
bind pph_io pph_monitor u_mon (.clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
  .p1_in, .strobe_low_lane, .strobe_high_lane, .irq_pending);

// *** pph_periph.sv ***
`timescale 1ns/1ps
module pph_periph (
  input wire logic clk,
  input wire pph_pkg::pph_pins_s p0_pins,
  input wire logic ready_low_lane,
  output logic strobe_low_lane,
  output logic strobe_high_lane,
  output logic [15:0] p0_in
);
  import pph_pkg::*;
  logic drv = 1'b0;
  logic [15:0] dat = 16'h0000;
  logic [15:0] seen;
  // released lines show the inverse of the last data, so stale values never match
  assign p0_in = drv ? dat : (p0_pins.oe & p0_pins.out) | (~p0_pins.oe & ~dat);
  initial begin
    strobe_low_lane = 1'b0;
    strobe_high_lane = 1'b0;
  end
  task automatic pulse(input bit hi, input int len);
    @(posedge clk);
    if (hi) strobe_high_lane <= 1'b1;
    else strobe_low_lane <= 1'b1;
    repeat (len) @(posedge clk);
    seen = p0_in;
    strobe_high_lane <= 1'b0;
    strobe_low_lane <= 1'b0;
    // three sync edges plus the registered ready, then one spare: five edges before callers look
    repeat (5) @(posedge clk);
  endtask : pulse
  task automatic send(input logic [15:0] d, input int len);
    int n;
    n = 0;
    while (ready_low_lane !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    drv <= 1'b1;
    dat <= d;
    pulse(1'b0, len);
    drv <= 1'b0;
  endtask : send
endmodule : pph_periph

// *** tb_parallel_port_handshake_io.sv ***
`timescale 1ns/1ps
`include "pph_map.svh"
module tb_parallel_port_handshake_io;
  import pph_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, strobe_low_lane, strobe_high_lane, ready_low_lane, ready_high_lane;
  logic b12 = 1'b0;
  logic [1:0] p4_gp;
  logic xi0_vector_external;
  logic [15:0] p0_in, p1_in, e, lf = 16'h004A, p1_drv = 16'hFFFF;
  logic [6:0] irq_pending;
  pph_pins_s p0_pins, p1_pins;
  logic [15:0] q[$];
  int fails = 0;
  int check_count = 0;
  always #25 clk = ~clk;
  // port 1 released lines read p1_drv, which is high except where the test pulls a line low
  assign p1_in = (p1_pins.oe & p1_pins.out) | (~p1_pins.oe & p1_drv);
  pph_io DUT (.clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'h3),
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .p0_in, .p0_pins, .p1_in, .p1_pins, .strobe_low_lane,
    .strobe_high_lane, .port4_input_bit12(b12), .port4_input_bit13(1'b0), .ready_low_lane,
    .ready_high_lane, .p4_gp_out(p4_gp), .irq_pending, .xi0_vector_external);
  pph_periph per (.clk, .p0_pins, .ready_low_lane, .strobe_low_lane, .strobe_high_lane,
    .p0_in);
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nx
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
    if (n >= 20) chk("ack", 1, 0);
  endtask : wb
  task automatic finish_test();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  initial begin
    #1000000;
    fails++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    wb(0, `PPH_A_P0_DIR, 0);
    chk("dir reset", 0, rd);
    wb(0, 8'h3C, 0);
    chk("hole", 0, rd);
    wb(1, `PPH_A_P1_ALT, 32'h70);
    for (int i = 0; i < 4; i++) begin
      lf = nx(lf);
      wb(1, `PPH_A_P0_DIR, lf);
      wb(1, `PPH_A_P0_DATA, lf);
      wb(1, `PPH_A_P1_DIR, ~lf);
      // pin registers follow the direction write one edge later
      @(posedge clk);
      chk("p0 drive", lf, p0_pins.oe & p0_pins.out);
      chk("p1 oe", ~lf & 16'hFF8F, p1_pins.oe);
    end
    wb(1, `PPH_A_P1_DIR, 0);
    wb(1, `PPH_A_EDGE, 1);
    p1_drv <= 16'hFF8F;
    b12 <= 1'b1;
    repeat (6) @(posedge clk);
    chk("pend fall", 7'h26, irq_pending);
    p1_drv <= 16'hFFDF;
    repeat (6) @(posedge clk);
    chk("pend rise", 7'h23, irq_pending);
    wb(1, `PPH_A_HS_CTRL, 32'h60);
    p1_drv <= 16'hFFEF;
    repeat (6) @(posedge clk);
    chk("vector ext", 1, xi0_vector_external);
    chk("expand oe", 0, p0_pins.oe);
    p1_drv <= 16'hFFFF;
    wb(1, `PPH_A_HS_CTRL, 0);
    per.pulse(0, 4);
    per.pulse(1, 4);
    wb(1, `PPH_A_PEND, 32'h7F);
    chk("pend clear", 0, irq_pending);
    wb(1, `PPH_A_P4_DATA, 32'hC1);
    @(posedge clk);
    chk("p4 out", 2'b11, p4_gp);
    chk("gp ready lo", 1, ready_low_lane);
    chk("gp ready hi", 0, ready_high_lane);
    wb(1, `PPH_A_HS_CTRL, 1);
    repeat (3) @(posedge clk);
    chk("in ready", 1, ready_low_lane);
    for (int i = 0; i < 2; i++) begin
      lf = nx(lf);
      q.push_back(lf);
      per.send(lf, 4 + 4 * i);
      chk("in full", 0, ready_low_lane);
      wb(0, `PPH_A_P0_DATA, 0);
      e = q.pop_front();
      chk("in data", e[7:0], rd[7:0]);
      repeat (3) @(posedge clk);
      chk("in ready", 1, ready_low_lane);
    end
    wb(1, `PPH_A_HS_CTRL, 2);
    lf = nx(lf);
    wb(1, `PPH_A_P0_DATA, lf);
    repeat (2) @(posedge clk);
    chk("out ready", 1, ready_low_lane);
    chk("out pins", lf[7:0], p0_pins.out[7:0]);
    per.pulse(0, 4);
    chk("out done", 0, ready_low_lane);
    wb(1, `PPH_A_HS_CTRL, 32'hC);
    lf = nx(lf);
    wb(1, `PPH_A_P0_DATA, lf);
    repeat (2) @(posedge clk);
    chk("bi ready", 1, ready_high_lane);
    chk("bi float", 0, p0_pins.oe);
    chk("bi empty", 1, ready_low_lane);
    per.pulse(1, 6);
    chk("bi bus", lf, per.seen);
    chk("bi acked", 0, ready_high_lane);
    lf = nx(lf);
    q.push_back(lf);
    per.send(lf, 8);
    wb(0, `PPH_A_P0_DATA, 0);
    chk("bi in", q.pop_front(), rd[15:0]);
    finish_test();
  end
endmodule : tb_parallel_port_handshake_io
